/* hw/adc_pkg.sv */
package adc_pkg;
  // Clock
  localparam int CLK_PERIOD_NS = 8;
  // Widths
  localparam int RES_W = 10;
  localparam int CH_W = 4;
  localparam int ADDR_W = 12;
  localparam int IDX_W = 10;
  localparam int STAB_W = 16;
  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CSR = 10'h070;
  localparam logic [IDX_W-1:0] IDX_RES_HI = 10'h071;
  localparam logic [IDX_W-1:0] IDX_RES_LO = 10'h072;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 10'h073;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h074;
  // Control/status fields
  localparam int CSR_DONE_BIT = 7;
  localparam int CSR_SPEED_BIT = 6;
  localparam int CSR_ON_BIT = 5;
  localparam int CSR_RSVD_BIT = 4;
  localparam int CH_LSB = 0;
  localparam int HI_LSB = 2;
  localparam int LO_W = 2;
  localparam int IRQ_DONE_BIT = 0;
  // Reset and fixed codes
  localparam logic [CH_W-1:0] CH_RESET = 4'h0;
  localparam logic [RES_W-1:0] RES_ZERO = 10'h000;
  localparam logic [RES_W-1:0] RES_FULL = 10'h3ff;
  localparam logic [RES_W-1:0] TRIAL_MSB = 10'h200;
  // Converter clock terminal counts: /4 and /2
  localparam logic [1:0] DIV_SLOW = 2'h3;
  localparam logic [1:0] DIV_FAST = 2'h1;
  // Conversion timing in converter clocks
  localparam logic [3:0] SAMPLE_TICKS = 4'h4;
  localparam logic [3:0] MSB_IDX = 4'h9;
  localparam logic [3:0] LSB_IDX = 4'h0;
  localparam logic [3:0] ONE4 = 4'h1;

  typedef enum logic [1:0] {s_idle, s_sample, s_step} sar_state_t;
endpackage

/* hw/sar_if.sv */
`timescale 1ns/100ps
interface sar_if;
  // Control from the register side
  logic run;
  logic abort;
  logic tick;
  logic cmp;
  // Converter state and result
  logic sampling;
  logic [adc_pkg::RES_W-1:0] trial;
  logic done;
  logic [adc_pkg::RES_W-1:0] result;

  modport ctrl (output run, abort, tick, cmp, input sampling, trial, done, result);
  modport engine (input run, abort, tick, cmp, output sampling, trial, done, result);
endinterface

/* hw/sar_engine.sv */
`timescale 1ns/100ps
module sar_engine (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Carrier to the register side
  sar_if.engine sar
);
  import adc_pkg::*;

  sar_state_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic half_q, half_d;
  logic [RES_W-1:0] trial_q, trial_d, res_q, res_d;
  logic samp_q, samp_d, done_q, done_d;
  logic all1_q, all1_d, all0_q, all0_d;

  assign sar.sampling = samp_q;
  assign sar.trial = trial_q;
  assign sar.done = done_q;
  assign sar.result = res_q;

  // Sample window, then one bit per two converter clocks, MSB first
  always_comb begin
    logic [RES_W-1:0] kept;
    kept = trial_q;
    kept[cnt_q] = sar.cmp;
    st_d = st_q;
    cnt_d = cnt_q;
    half_d = half_q;
    trial_d = trial_q;
    res_d = res_q;
    done_d = 1'b0;
    all1_d = all1_q;
    all0_d = all0_q;
    case (st_q)
      s_idle: begin
        st_d = s_sample;
        cnt_d = LSB_IDX;
      end
      s_sample: begin
        if (sar.tick) begin
          if (cnt_q == SAMPLE_TICKS - ONE4) begin
            st_d = s_step;
            cnt_d = MSB_IDX;
            half_d = 1'b0;
            trial_d = TRIAL_MSB;
            all1_d = 1'b1;
            all0_d = 1'b1;
          end else begin
            cnt_d = cnt_q + ONE4;
          end
        end
      end
      s_step: begin
        // The first clock lets the trial settle past the comparator synchroniser
        if (sar.tick) begin
          half_d = ~half_q;
          if (half_q) begin
            trial_d = kept;
            all1_d = all1_q & sar.cmp;
            all0_d = all0_q & ~sar.cmp;
            if (cnt_q == LSB_IDX) begin
              // Comparator stuck high or low gives all ones or zero
              res_d = kept;
              done_d = 1'b1;
              st_d = s_sample;
              cnt_d = LSB_IDX;
              trial_d = RES_ZERO;
            end else begin
              trial_d[cnt_q - ONE4] = 1'b1;
              cnt_d = cnt_q - ONE4;
            end
          end
        end
      end
      default: st_d = s_idle;
    endcase
    // Off, halt or channel change drops the conversion in flight
    if (sar.abort || !sar.run) begin
      st_d = s_idle;
      trial_d = RES_ZERO;
      done_d = 1'b0;
    end
    samp_d = (st_d == s_sample);
  end

  // State registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= s_idle;
      cnt_q <= LSB_IDX;
      half_q <= 1'b0;
      trial_q <= RES_ZERO;
      res_q <= RES_ZERO;
      samp_q <= 1'b0;
      done_q <= 1'b0;
      all1_q <= 1'b0;
      all0_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      half_q <= half_d;
      trial_q <= trial_d;
      res_q <= res_d;
      samp_q <= samp_d;
      done_q <= done_d;
      all1_q <= all1_d;
      all0_q <= all0_d;
    end
  end

  chk_sat_high: assert property (@(posedge pclk) disable iff (!presetn)
    done_q && all1_q |-> res_q == RES_FULL) else $error("saturated input not all ones");
  chk_sat_low: assert property (@(posedge pclk) disable iff (!presetn)
    done_q && all0_q |-> res_q == RES_ZERO) else $error("input below reference not zero");
  chk_steps_msb: assert property (@(posedge pclk) disable iff (!presetn)
    st_q == s_sample && $past(st_q) == s_sample ##1 st_q == s_step |-> trial_q == TRIAL_MSB)
    else $error("first trial is not the top bit");
endmodule // sar_engine

/* hw/adc_ctrl.sv */
// Summary of operation
// - Input above upper reference reads all ones
// - Input below lower reference reads zero
// - Four-bit field picks input zero to fifteen
// - Converter on starts continuous back-to-back conversion
// - Converter off stops conversion in progress
// - Conversion end stores result, sets done flag
// - High-byte read or control write clears done
// - New channel aborts, clears done, restarts
// - Speed bit picks clock divide four or two
// - Control register resets zero, done read-only
// - High byte returns result bits nine to two
// - Low register returns bits one, zero; rest zero
// - Wait unaffected; halt disables, then stabilization wait
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module adc_ctrl #(
  parameter int STAB_TIME_NS = 1000
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [adc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Power mode from the system
  input wire logic halt_mode,
  // Analog front end
  output logic [adc_pkg::CH_W-1:0] channel_select,
  output logic converter_enable,
  output logic sample_hold,
  output logic [adc_pkg::RES_W-1:0] dac_code,
  input wire logic cmp_in,
  // Interrupt
  output logic irq
);
  import adc_pkg::*;

  localparam int STAB_CYCLES = (STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  sar_if sar ();

  // Register index from a byte address
  function automatic logic [IDX_W-1:0] reg_idx(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:2];
  endfunction

  logic eoc_q, eoc_d, speed_q, speed_d, on_q, on_d, rsvd_q, rsvd_d;
  logic [CH_W-1:0] ch_q, ch_d;
  logic [RES_W-1:0] result_q, result_d;
  logic stat_q, stat_d, mask_q, mask_d, irq_q, irq_d;
  logic [1:0] div_q, div_d;
  logic [STAB_W-1:0] stab_q, stab_d;
  logic cmp_s1_q, cmp_s2_q;
  logic en_q, en_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic setup, fire, wr_csr, rd_hi, abort, tick, rd_err;
  logic [7:0] csr_byte;
  logic [31:0] rdata;

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign channel_select = ch_q;
  assign converter_enable = en_q;
  assign sample_hold = sar.sampling;
  assign dac_code = sar.trial;
  assign irq = irq_q;

  // Bus phases; writes and read side effects land on the completing edge
  assign setup = psel & ~penable;
  assign fire = psel & penable & pready_q;
  assign wr_csr = fire & pwrite & (reg_idx(paddr) == IDX_CSR);
  assign rd_hi = fire & ~pwrite & (reg_idx(paddr) == IDX_RES_HI);
  assign abort = wr_csr & (pwdata[CH_LSB +: CH_W] != ch_q);
  assign csr_byte = {eoc_q, speed_q, on_q, rsvd_q, ch_q};

  // Converter clock as a one-cycle enable
  assign tick = (div_q == (speed_q ? DIV_FAST : DIV_SLOW));

  // Carrier drive
  assign sar.tick = tick;
  assign sar.cmp = cmp_s2_q;
  assign sar.abort = abort;
  assign sar.run = on_q & ~halt_mode & (stab_q == '0);

  // Read multiplexer, sampled in the setup cycle
  always_comb begin
    rdata = 32'h0000_0000;
    rd_err = 1'b0;
    case (reg_idx(paddr))
      IDX_CSR: rdata = 32'(csr_byte);
      IDX_RES_HI: rdata = 32'(result_q[RES_W-1:HI_LSB]);
      IDX_RES_LO: rdata = 32'(result_q[LO_W-1:0]);
      IDX_IRQ_STAT: rdata = 32'(stat_q);
      IDX_IRQ_MASK: rdata = 32'(mask_q);
      default: rd_err = 1'b1;
    endcase
  end

  // Bus answer: one wait-free access phase, error on unmapped index
  always_comb begin
    pready_d = setup;
    pslverr_d = setup & rd_err;
    prdata_d = setup ? rdata : prdata_q;
  end

  // Control/status, result and interrupt next values
  always_comb begin
    speed_d = speed_q;
    on_d = on_q;
    rsvd_d = rsvd_q;
    ch_d = ch_q;
    result_d = result_q;
    eoc_d = eoc_q;
    mask_d = mask_q;
    stat_d = stat_q;
    if (wr_csr) begin
      speed_d = pwdata[CSR_SPEED_BIT];
      on_d = pwdata[CSR_ON_BIT];
      rsvd_d = pwdata[CSR_RSVD_BIT];
      ch_d = pwdata[CH_LSB +: CH_W];
    end
    if (fire && pwrite && reg_idx(paddr) == IDX_IRQ_MASK) begin
      mask_d = pwdata[IRQ_DONE_BIT];
    end
    if (fire && pwrite && reg_idx(paddr) == IDX_IRQ_STAT && pwdata[IRQ_DONE_BIT]) begin
      stat_d = 1'b0;
    end
    // Done flag: read of high byte or any control write clears it
    if (wr_csr || rd_hi) begin
      eoc_d = 1'b0;
    end
    // A finishing conversion wins over a clear in the same cycle
    if (sar.done) begin
      result_d = sar.result;
      eoc_d = 1'b1;
      stat_d = 1'b1;
    end
    irq_d = stat_d & mask_d;
  end

  // Divider, halt recovery and analog enable
  always_comb begin
    div_d = tick ? 2'h0 : div_q + 2'h1;
    // Halt reloads the stabilization wait; conversions resume when it expires
    if (halt_mode) begin
      stab_d = STAB_W'(STAB_CYCLES);
    end else if (stab_q != '0) begin
      stab_d = stab_q - STAB_W'(1);
    end else begin
      stab_d = stab_q;
    end
    en_d = on_q & ~halt_mode;
  end

  // Register file and bus answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eoc_q <= 1'b0;
      speed_q <= 1'b0;
      on_q <= 1'b0;
      rsvd_q <= 1'b0;
      ch_q <= CH_RESET;
      result_q <= RES_ZERO;
      stat_q <= 1'b0;
      mask_q <= 1'b0;
      irq_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      eoc_q <= eoc_d;
      speed_q <= speed_d;
      on_q <= on_d;
      rsvd_q <= rsvd_d;
      ch_q <= ch_d;
      result_q <= result_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Timing state; comparator pin is asynchronous so it is synchronised first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 2'h0;
      stab_q <= '0;
      en_q <= 1'b0;
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
    end else begin
      div_q <= div_d;
      stab_q <= stab_d;
      en_q <= en_d;
      cmp_s1_q <= cmp_in;
      cmp_s2_q <= cmp_s1_q;
    end
  end

  sar_engine u_engine (
    .pclk(pclk),
    .presetn(presetn),
    .sar(sar.engine)
  );

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Channel field follows the completing write
  chk_channel_write: assert property (wr_csr |=> channel_select == $past(pwdata[CH_LSB +: CH_W]))
    else $error("channel select not taken from write");

  // On bit follows the completing write
  chk_on_write: assert property (wr_csr |=> on_q == $past(pwdata[CSR_ON_BIT]))
    else $error("on bit not taken from write");

  // Next window opens on the cycle the result lands, no idle gap
  chk_continuous_run: assert property (sar.done |-> sample_hold)
    else $error("converter did not restart after a conversion");

  // Off parks the engine and powers the analog side down a cycle later
  chk_off_stops: assert property (!on_q |=> !sample_hold && dac_code == RES_ZERO && !converter_enable)
    else $error("converter still active while off");

  // Result and flag appear together
  chk_done_sets: assert property (sar.done |=> eoc_q && result_q == $past(sar.result))
    else $error("result or done flag not updated");

  // Software may clear the flag but never set it
  chk_done_readonly: assert property (wr_csr && !sar.done |=> !eoc_q)
    else $error("control write left done set");

  // Only a finishing conversion keeps the flag through a high read
  chk_read_clears: assert property (rd_hi && !sar.done |=> !eoc_q)
    else $error("high byte read left done set");

  // Restart costs one idle cycle, unless halt lands in between
  chk_abort_restart: assert property (abort && !sar.done && pwdata[CSR_ON_BIT] && !halt_mode
    && stab_q == '0 |=> !eoc_q && !sample_hold ##1 (sample_hold || $past(halt_mode)))
    else $error("channel change did not restart conversion");

  // Speed bit follows the completing write
  chk_speed_write: assert property (wr_csr |=> speed_q == $past(pwdata[CSR_SPEED_BIT]))
    else $error("speed bit not taken from write");

  // Rate checks let a speed change land mid-period
  chk_fast_clock: assert property (tick && speed_q && $past(speed_q) |=> !tick ##1 (tick || !speed_q))
    else $error("divide by two spacing wrong");

  // A switch to the fast rate may cut the slow period short
  chk_slow_clock: assert property (tick && !speed_q |=> (!tick || speed_q) [*3] ##1 (tick || speed_q))
    else $error("divide by four spacing wrong");

  // Control read returns the stored byte, upper bits zero
  chk_csr_read: assert property (setup && !pwrite && reg_idx(paddr) == IDX_CSR |=>
    prdata_q == 32'($past(csr_byte)))
    else $error("control read data wrong");

  // High byte carries the top eight result bits
  chk_high_byte: assert property (setup && !pwrite && reg_idx(paddr) == IDX_RES_HI |=>
    prdata_q == 32'($past(result_q[RES_W-1:HI_LSB])))
    else $error("high result byte wrong");

  // Low register carries the two bottom result bits
  chk_low_bits: assert property (setup && !pwrite && reg_idx(paddr) == IDX_RES_LO |=>
    prdata_q[LO_W-1:0] == $past(result_q[LO_W-1:0]))
    else $error("low result bits wrong");

  // Low register upper bits never leak anything
  chk_low_reserved: assert property (fire && !pwrite && reg_idx(paddr) == IDX_RES_LO |-> prdata_q[31:2] == '0)
    else $error("low result reserved bits not zero");

  // Answer is a single wait-free access cycle
  chk_ready_pulse: assert property (setup |=> pready ##1 !pready)
    else $error("ready not a single cycle after setup");

  // Unmapped index answers with an error on the same cycle as ready
  chk_error_unmapped: assert property (setup && rd_err |=> pslverr && pready)
    else $error("unmapped access without error");

  // Halt drops the analog enable and the engine together, a cycle later
  chk_halt_off: assert property (halt_mode |=> !converter_enable ##1 !sample_hold)
    else $error("converter active during halt");

  // Leaving halt must not restart before the settling wait
  chk_halt_wait: assert property ($fell(halt_mode) |-> stab_q != '0 && !sar.run)
    else $error("converter restarted without settling");

  // Interrupt level tracks unmasked status
  chk_irq_level: assert property (irq == (stat_q & mask_q))
    else $error("interrupt level not status and mask");
endmodule // adc_ctrl

/* dv/afe_model.sv */
`timescale 1ns/100ps
module afe_model (
  // Clock
  input wire logic pclk,
  // Converter side
  input wire logic [adc_pkg::CH_W-1:0] channel_select,
  input wire logic converter_enable,
  input wire logic sample_hold,
  input wire logic [adc_pkg::RES_W-1:0] dac_code,
  // Level per input; above 3ff means over the upper reference
  input wire logic [10:0] level [16],
  output logic cmp_in
);
  import adc_pkg::*;
  logic [10:0] held_q = 11'h000;
  logic junk_q = 1'b0;
  // Hold stays frozen through the steps, so a moving input cannot skew the code
  always_ff @(posedge pclk) begin
    if (sample_hold) held_q <= level[channel_select];
    junk_q <= ~junk_q;
  end
  // Powered-down comparator gives garbage, not a stable level
  assign cmp_in = converter_enable ? (held_q >= {1'b0, dac_code}) : junk_q;
endmodule // afe_model

/* dv/adc_control_status_logic_tb_top.sv */
`timescale 1ns/100ps
module adc_control_status_logic_tb_top;
  import adc_pkg::*;
  localparam logic [11:0] A_CSR = {IDX_CSR, 2'b00};
  localparam logic [11:0] A_HI = {IDX_RES_HI, 2'b00};
  localparam logic [11:0] A_LO = {IDX_RES_LO, 2'b00};
  localparam logic [11:0] A_IST = {IDX_IRQ_STAT, 2'b00};
  localparam logic [11:0] A_IMK = {IDX_IRQ_MASK, 2'b00};
  localparam logic [11:0] A_BAD = 12'h1d4;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, halt_mode = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, converter_enable, sample_hold, cmp_in, irq;
  logic [3:0] channel_select;
  logic [9:0] dac_code;
  logic [10:0] level [16];
  logic [31:0] rd;
  logic err;
  logic [9:0] res;
  int fail_count = 0, tests_run = 0, n;

  adc_ctrl #(.STAB_TIME_NS(80)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .halt_mode(halt_mode), .channel_select(channel_select), .converter_enable(converter_enable),
    .sample_hold(sample_hold), .dac_code(dac_code), .cmp_in(cmp_in), .irq(irq));
  afe_model u_afe (.pclk(pclk), .channel_select(channel_select), .converter_enable(converter_enable),
    .sample_hold(sample_hold), .dac_code(dac_code), .level(level), .cmp_in(cmp_in));

  // Clock
  initial begin
    forever #(CLK_PERIOD_NS / 2) pclk = ~pclk;
  end

  // Verdict and end of run
  task automatic complete_run();
    if (fail_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic hang(input string name);
    fail_count++;
    $display("ERROR %s expected completion seen timeout", name);
    complete_run();
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 50) hang("pready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Poll done, then low before high as software must
  task automatic get_result();
    int k;
    for (k = 0; k < 400; k++) begin
      apb(1'b0, A_CSR, 8'h00);
      if (rd[CSR_DONE_BIT] === 1'b1) break;
    end
    if (k == 400) hang("done flag");
    apb(1'b0, A_LO, 8'h00);
    check("low reserved bits", {rd[31:2], 2'b00}, 32'h0);
    res[1:0] = rd[1:0];
    apb(1'b0, A_HI, 8'h00);
    res[9:2] = rd[7:0];
    apb(1'b0, A_CSR, 8'h00);
    check("done after high read", rd[CSR_DONE_BIT], 1'b0);
  endtask

  // Cycles between two sample window starts; one window skipped, as a restart is not tick aligned
  task automatic period(output int c);
    int k;
    for (int w = 0; w < 2; w++) begin
      for (k = 0; k < 300 && !(sample_hold === 1'b0); k++) @(posedge pclk);
      for (k = 0; k < 300 && !(sample_hold === 1'b1); k++) @(posedge pclk);
    end
    for (c = 0; c < 300 && !(sample_hold === 1'b0); c++) @(posedge pclk);
    for (k = 0; k < 300 && !(sample_hold === 1'b1); k++) @(posedge pclk);
    if (k == 300) hang("sample window");
    c = c + k;
  endtask

  initial begin
    for (int i = 0; i < 16; i++) level[i] = 11'(i * 61 + 7);
    level[14] = 11'h7ff;
    level[15] = 11'h000;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and refused address
    apb(1'b0, A_CSR, 8'h00);
    check("csr reset", rd, 32'h0);
    apb(1'b0, A_HI, 8'h00);
    check("high reset", rd, 32'h0);
    apb(1'b0, A_LO, 8'h00);
    check("low reset", rd, 32'h0);
    apb(1'b0, A_BAD, 8'h00);
    check("unmapped error", err, 1'b1);
    // Done bit cannot be written
    apb(1'b1, A_CSR, 8'h8a);
    apb(1'b0, A_CSR, 8'h00);
    check("csr write", rd, 32'h0a);
    check("channel out", channel_select, 4'ha);
    // Every channel, both clock speeds, plus both saturation cases
    for (int ch = 0; ch < 16; ch++) begin
      // Off first, so a result finishing on the switch cannot pass for the new channel
      apb(1'b1, A_CSR, 8'h00);
      apb(1'b1, A_CSR, 8'h20 | 8'(ch) | ((ch % 2) ? 8'h40 : 8'h00));
      get_result();
      check("result", res, (ch == 14) ? 10'h3ff : level[ch][9:0]);
    end
    // Conversions run back to back at the chosen rate
    period(n);
    check("period fast", n, 48);
    apb(1'b1, A_CSR, 8'h23);
    period(n);
    check("period slow", n, 96);
    // Control write clears done; channel change aborts and restarts
    get_result();
    apb(1'b1, A_IMK, 8'h01);
    get_result();
    check("irq raised", irq, 1'b1);
    apb(1'b1, A_IST, 8'h01);
    apb(1'b0, A_IST, 8'h00);
    check("irq status clear", rd[0], 1'b0);
    check("irq low", irq, 1'b0);
    for (n = 0; n < 300 && irq !== 1'b1; n++) @(posedge pclk);
    if (n == 300) hang("interrupt");
    apb(1'b1, A_CSR, 8'h23);
    apb(1'b0, A_CSR, 8'h00);
    check("done after csr write", rd[CSR_DONE_BIT], 1'b0);
    repeat (30) @(posedge pclk);
    apb(1'b1, A_CSR, 8'h25);
    apb(1'b0, A_CSR, 8'h00);
    check("done after channel change", rd[CSR_DONE_BIT], 1'b0);
    get_result();
    check("new channel result", res, level[5][9:0]);
    apb(1'b1, A_IMK, 8'h00);
    // Halt stops the converter, then it resumes after settling
    halt_mode <= 1'b1;
    repeat (4) @(posedge pclk);
    check("enable in halt", converter_enable, 1'b0);
    halt_mode <= 1'b0;
    apb(1'b1, A_CSR, 8'h27);
    get_result();
    check("result after halt", res, level[7][9:0]);
    // Eight-bit use: poll done, then the high byte only
    for (n = 0; n < 400 && rd[CSR_DONE_BIT] !== 1'b1; n++) apb(1'b0, A_CSR, 8'h00);
    if (n == 400) hang("done flag");
    apb(1'b0, A_HI, 8'h00);
    check("high byte only", rd, {24'h0, level[7][9:2]});
    apb(1'b0, A_CSR, 8'h00);
    check("done after high only", rd[CSR_DONE_BIT], 1'b0);
    // Switching off stops everything
    apb(1'b1, A_CSR, 8'h07);
    repeat (3) @(posedge pclk);
    check("enable off", converter_enable, 1'b0);
    repeat (200) @(posedge pclk);
    apb(1'b0, A_CSR, 8'h00);
    check("no done when off", rd[CSR_DONE_BIT], 1'b0);
    complete_run();
  end
endmodule // adc_control_status_logic_tb_top
